// ### fpe_map.svh
// Function
// - Self erase covers whole 1024-byte blocks only
// - Erase block chosen by pointer bits 21:10
// - Erase or program needs write enable set
// - Erase select bit 4, write enable bit 2
// - Key writes 55h then 0AAh unlock start
// - Write start after unlock with erase select begins block erase
// - CPU stalls during every long write
// - Internal timer or a reset abort ends the long write
// - Programming only in 64-byte blocks
// - Sixty-four byte holding registers hold program data
// - Table write loads holding register, no flash
// - Control write copies holding registers into flash
// - Holding registers keep contents after programming
// - Larger erases never from on-chip code
// - Post-increment read loads latch, bumps pointer
// - Flash targeted only with memory select, no config
// - Write start settable only, hardware clears it
// - Holding index from low pointer bits
// - Reset during write sets write error flag
`ifndef FPE_MAP_SVH
`define FPE_MAP_SVH
`define FPE_OFS_CTRL 8'h00
`define FPE_OFS_KEY 8'h04
`define FPE_OFS_LATCH 8'h08
`define FPE_OFS_PTR 8'h0c
`define FPE_OFS_TOP 8'h10
`define FPE_OFS_STAT 8'h14
`define FPE_BIT_PGM 7
`define FPE_BIT_CFG 6
`define FPE_BIT_ERASE 4
`define FPE_BIT_WERR 3
`define FPE_BIT_WRITE_ENABLE_BIT 2
`define FPE_BIT_WR 1
`define FPE_BIT_TOP_WR 2
`define FPE_KEY_FIRST 8'h55
`define FPE_KEY_SECOND 8'haa
`define FPE_RST_HOLD 8'hff
`define FPE_RST_LATCH 8'h00
`define FPE_HOLD_DEPTH 64
`define FPE_TIW_US 1000
`define FPE_CLK_MHZ 25
`define FPE_TIW_CYC (`FPE_TIW_US * `FPE_CLK_MHZ)
`endif

// ### fpe_pkg.sv
package fpe_pkg;
  typedef enum logic [1:0] {
    FPE_IDLE = 2'b00,
    FPE_COPY = 2'b01,
    FPE_WAIT = 2'b11,
    FPE_ERASE = 2'b10
  } fpe_state_e;
  typedef enum logic [1:0] {
    FPE_KEY_NONE = 2'b00,
    FPE_KEY_HALF = 2'b01,
    FPE_KEY_OPEN = 2'b11
  } fpe_key_e;
  typedef enum logic [1:0] {
    FPE_TM_KEEP = 2'b00,
    FPE_TM_POSTINC = 2'b01,
    FPE_TM_POSTDEC = 2'b10,
    FPE_TM_PREINC = 2'b11
  } fpe_tmode_e;
endpackage

// ### fpe_timer.sv
`timescale 1ns/10ps
`default_nettype none
module fpe_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic start,
  input wire logic stop,
  input wire logic [CNT_W-1:0] load,
  // Status.
  output logic running,
  output logic done
);
  logic [CNT_W-1:0] cnt_ff;
  logic run_ff;

  initial begin
    if (CNT_W < 8 || CNT_W > 24) begin
      $error("fpe_timer: CNT_W out of range");
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else if (stop) begin
      run_ff <= 1'b0;
    end else if (start) begin
      cnt_ff <= load;
      run_ff <= 1'b1;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - 1'b1;
      run_ff <= (cnt_ff != {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  assign running = run_ff;
  assign done = run_ff && (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule // fpe_timer
`default_nettype wire

// ### fpe_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpe_map.svh"
module fpe_ctrl #(
  parameter int LONG_WRITE_CYCLES = `FPE_TIW_CYC,
  parameter int PTR_W = 22
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Reset-abort request from the reset controller, asynchronous.
  input wire logic write_abort,
  // Flash array read port; data must stand in the cycle the read enable is high.
  output logic flash_rd_en,
  output logic [PTR_W-1:0] flash_rd_addr,
  input wire logic [7:0] flash_rd_data,
  // Flash array erase and byte program strobes.
  output logic flash_erase_strobe,
  output logic [11:0] flash_erase_block,
  output logic flash_wr_strobe,
  output logic [PTR_W-1:0] flash_wr_addr,
  output logic [7:0] flash_wr_data,
  // Core stall.
  output logic cpu_stall
);
  localparam int DEPTH = `FPE_HOLD_DEPTH;

  initial begin
    if (PTR_W != 22 || LONG_WRITE_CYCLES <= DEPTH || LONG_WRITE_CYCLES > 65535) begin
      $error("fpe_ctrl: unsupported parameter value");
    end
  end

  fpe_pkg::fpe_state_e state_ff;
  fpe_pkg::fpe_key_e key_ff;
  logic pgm_sel_ff, cfg_sel_ff, erase_sel_ff, write_enable_bit_ff, wr_ff, werr_ff;
  logic [7:0] latch_ff;
  logic [PTR_W-1:0] ptr_ff;
  logic [7:0] hold_mem [0:DEPTH-1];
  logic [5:0] copy_idx_ff;
  logic rd_pend_ff;
  logic [31:0] prdata_ff;
  logic ab1_ff, ab2_ff, ab3_ff, ab_lvl_ff;
  logic tmr_run, tmr_done;

  // APB decode.
  logic acc, wr_acc, hit, abort_evt, start_ok, tw_go, tr_go;
  logic [7:0] nxt_prdata_b;
  logic [PTR_W-1:0] eff_ptr, nxt_ptr;
  fpe_pkg::fpe_tmode_e tmode;

  assign cpu_stall = (state_ff != fpe_pkg::FPE_IDLE);
  assign pready = !cpu_stall && !rd_pend_ff;
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign hit = (paddr == `FPE_OFS_CTRL) || (paddr == `FPE_OFS_KEY) ||
               (paddr == `FPE_OFS_LATCH) || (paddr == `FPE_OFS_PTR) ||
               (paddr == `FPE_OFS_TOP) || (paddr == `FPE_OFS_STAT);
  assign pslverr = psel && penable && pready && !hit;
  assign prdata = prdata_ff;

  // A start is taken only from the access right after a complete key.
  assign start_ok = wr_acc && (paddr == `FPE_OFS_CTRL) && pwdata[`FPE_BIT_WR] &&
                    (key_ff == fpe_pkg::FPE_KEY_OPEN) &&
                    pwdata[`FPE_BIT_WRITE_ENABLE_BIT] &&
                    pwdata[`FPE_BIT_PGM] && !pwdata[`FPE_BIT_CFG];

  assign tmode = fpe_pkg::fpe_tmode_e'(pwdata[1:0]);
  assign tw_go = wr_acc && (paddr == `FPE_OFS_TOP) && pwdata[`FPE_BIT_TOP_WR];
  assign tr_go = wr_acc && (paddr == `FPE_OFS_TOP) && !pwdata[`FPE_BIT_TOP_WR];

  // Pointer steps touch only the low 21 bits; bit 21 selects config space.
  always_comb begin
    eff_ptr = ptr_ff;
    nxt_ptr = ptr_ff;
    case (tmode)
      fpe_pkg::FPE_TM_POSTINC: begin
        nxt_ptr = {ptr_ff[21], ptr_ff[20:0] + 21'h000001};
      end
      fpe_pkg::FPE_TM_POSTDEC: begin
        nxt_ptr = {ptr_ff[21], ptr_ff[20:0] - 21'h000001};
      end
      fpe_pkg::FPE_TM_PREINC: begin
        eff_ptr = {ptr_ff[21], ptr_ff[20:0] + 21'h000001};
        nxt_ptr = eff_ptr;
      end
      default: begin
        nxt_ptr = ptr_ff;
      end
    endcase
  end

  // Reset-abort input passes three flops; a change counts when two agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab1_ff <= 1'b0;
      ab2_ff <= 1'b0;
      ab3_ff <= 1'b0;
      ab_lvl_ff <= 1'b0;
    end else begin
      ab1_ff <= write_abort;
      ab2_ff <= ab1_ff;
      ab3_ff <= ab2_ff;
      if (ab2_ff == ab3_ff) begin
        ab_lvl_ff <= ab3_ff;
      end
    end
  end
  assign abort_evt = (ab2_ff == ab3_ff) && ab3_ff && !ab_lvl_ff;

  // Unlock tracking: any other completed access cancels a partial key.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_ff <= fpe_pkg::FPE_KEY_NONE;
    end else if (acc) begin
      if (wr_acc && paddr == `FPE_OFS_KEY && pwdata[7:0] == `FPE_KEY_FIRST) begin
        key_ff <= fpe_pkg::FPE_KEY_HALF;
      end else if (wr_acc && paddr == `FPE_OFS_KEY && pwdata[7:0] == `FPE_KEY_SECOND &&
                   key_ff == fpe_pkg::FPE_KEY_HALF) begin
        key_ff <= fpe_pkg::FPE_KEY_OPEN;
      end else begin
        key_ff <= fpe_pkg::FPE_KEY_NONE;
      end
    end
  end

  // Control bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pgm_sel_ff <= 1'b0;
      cfg_sel_ff <= 1'b0;
      erase_sel_ff <= 1'b0;
      write_enable_bit_ff <= 1'b0;
    end else if (wr_acc && paddr == `FPE_OFS_CTRL) begin
      pgm_sel_ff <= pwdata[`FPE_BIT_PGM];
      cfg_sel_ff <= pwdata[`FPE_BIT_CFG];
      erase_sel_ff <= pwdata[`FPE_BIT_ERASE];
      write_enable_bit_ff <= pwdata[`FPE_BIT_WRITE_ENABLE_BIT];
    end
  end

  // Write start: software can only set it, the cycle end clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ff <= 1'b0;
    end else if (start_ok && !abort_evt) begin
      // An abort in the start cycle squashes the start, so no busy bit is stranded.
      wr_ff <= 1'b1;
    end else if (tmr_done || abort_evt) begin
      wr_ff <= 1'b0;
    end
  end

  // Error flag: survives until power-on reset or a software write of zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      werr_ff <= 1'b0;
    end else if (abort_evt && cpu_stall) begin
      werr_ff <= 1'b1;
    end else if (wr_acc && paddr == `FPE_OFS_CTRL && !pwdata[`FPE_BIT_WERR]) begin
      werr_ff <= 1'b0;
    end
  end

  // Long write sequencing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= fpe_pkg::FPE_IDLE;
      copy_idx_ff <= 6'h00;
    end else if (abort_evt) begin
      state_ff <= fpe_pkg::FPE_IDLE;
    end else begin
      case (state_ff)
        fpe_pkg::FPE_IDLE: begin
          copy_idx_ff <= 6'h00;
          if (start_ok && pwdata[`FPE_BIT_ERASE]) begin
            state_ff <= fpe_pkg::FPE_ERASE;
          end else if (start_ok) begin
            state_ff <= fpe_pkg::FPE_COPY;
          end
        end
        fpe_pkg::FPE_COPY: begin
          copy_idx_ff <= copy_idx_ff + 6'h01;
          if (copy_idx_ff == 6'h3f) begin
            state_ff <= fpe_pkg::FPE_WAIT;
          end
        end
        fpe_pkg::FPE_WAIT, fpe_pkg::FPE_ERASE: begin
          if (tmr_done) begin
            state_ff <= fpe_pkg::FPE_IDLE;
          end
        end
        default: begin
          state_ff <= fpe_pkg::FPE_IDLE;
        end
      endcase
    end
  end

  fpe_timer #(
    .CNT_W(16)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_ok),
    .stop(abort_evt),
    .load(16'(LONG_WRITE_CYCLES)),
    .running(tmr_run),
    .done(tmr_done)
  );

  // Flash strobes. Only one block erase exists; no wider erase is reachable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_erase_strobe <= 1'b0;
      flash_erase_block <= 12'h000;
      flash_wr_strobe <= 1'b0;
      flash_wr_addr <= '0;
      flash_wr_data <= 8'h00;
    end else begin
      flash_erase_strobe <= start_ok && pwdata[`FPE_BIT_ERASE] && !abort_evt;
      if (start_ok) begin
        flash_erase_block <= ptr_ff[21:10];
      end
      flash_wr_strobe <= (state_ff == fpe_pkg::FPE_COPY) && !abort_evt;
      flash_wr_addr <= {ptr_ff[21:6], copy_idx_ff};
      flash_wr_data <= hold_mem[copy_idx_ff];
    end
  end

  // Holding registers are never cleared by a program cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        hold_mem[i] <= `FPE_RST_HOLD;
      end
    end else if (tw_go) begin
      hold_mem[eff_ptr[5:0]] <= latch_ff;
    end
  end

  // Table pointer, latch and the two-cycle table read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_ff <= '0;
      latch_ff <= `FPE_RST_LATCH;
      rd_pend_ff <= 1'b0;
      flash_rd_en <= 1'b0;
      flash_rd_addr <= '0;
    end else begin
      flash_rd_en <= tr_go;
      rd_pend_ff <= tr_go;
      if (tr_go) begin
        flash_rd_addr <= eff_ptr;
      end
      if (rd_pend_ff) begin
        latch_ff <= flash_rd_data;
      end else if (wr_acc && paddr == `FPE_OFS_LATCH) begin
        latch_ff <= pwdata[7:0];
      end
      if (tr_go || tw_go) begin
        ptr_ff <= nxt_ptr;
      end else if (wr_acc && paddr == `FPE_OFS_PTR) begin
        ptr_ff <= pwdata[PTR_W-1:0];
      end
    end
  end

  // Read data is registered one cycle ahead of the access phase.
  always_comb begin
    nxt_prdata_b = 8'h00;
    case (paddr)
      `FPE_OFS_CTRL: begin
        nxt_prdata_b = {pgm_sel_ff, cfg_sel_ff, 1'b0, erase_sel_ff, werr_ff, write_enable_bit_ff,
                        wr_ff, 1'b0};
      end
      `FPE_OFS_LATCH: begin
        // A read set up right behind a table read must see the byte now arriving.
        nxt_prdata_b = rd_pend_ff ? flash_rd_data : latch_ff;
      end
      `FPE_OFS_STAT: begin
        nxt_prdata_b = {3'h0, tmr_run, key_ff, state_ff};
      end
      default: begin
        nxt_prdata_b = 8'h00;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (psel && paddr == `FPE_OFS_PTR) begin
      prdata_ff <= {10'h000, ptr_ff};
    end else if (psel) begin
      prdata_ff <= {24'h000000, nxt_prdata_b};
    end
  end

  sequence s_tr_issue;
    tr_go && tmode == fpe_pkg::FPE_TM_POSTINC;
  endsequence
  sequence s_tr_land;
    ##2 latch_ff == $past(flash_rd_data);
  endsequence

  AST_ERASE_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    flash_erase_strobe |-> flash_erase_block == ptr_ff[21:10])
    else $error("erase block does not match pointer");
  AST_START_KEYED: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wr_ff) |-> $past(key_ff) == fpe_pkg::FPE_KEY_OPEN && $past(pwdata[`FPE_BIT_WRITE_ENABLE_BIT]))
    else $error("write start without unlock or enable");
  AST_STALL: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ff |-> cpu_stall && !pready)
    else $error("cpu not stalled during long write");
  AST_TIMER_END: assert property (@(posedge pclk) disable iff (!presetn)
    tmr_done && !abort_evt |=> !wr_ff && !cpu_stall)
    else $error("timer end did not release stall");
  AST_WR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ff && !tmr_done && !abort_evt |=> wr_ff)
    else $error("write start cleared early");
  AST_PROG_DATA: assert property (@(posedge pclk) disable iff (!presetn)
    flash_wr_strobe |-> flash_wr_data == hold_mem[flash_wr_addr[5:0]])
    else $error("programmed byte differs from holding register");
  AST_TW_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    tw_go |=> hold_mem[$past(eff_ptr[5:0])] == $past(latch_ff) && !flash_wr_strobe)
    else $error("table write did not load holding register");
  AST_TR_INC: assert property (@(posedge pclk) disable iff (!presetn)
    s_tr_issue |-> s_tr_land)
    else $error("table read did not land in latch");
  AST_PTR_INC: assert property (@(posedge pclk) disable iff (!presetn)
    s_tr_issue |=> ptr_ff[20:0] == $past(ptr_ff[20:0]) + 21'h000001)
    else $error("pointer not incremented after read");
  AST_WERR: assert property (@(posedge pclk) disable iff (!presetn)
    abort_evt && cpu_stall |=> werr_ff && !cpu_stall)
    else $error("aborted write not flagged");
  AST_KEY_CANCEL: assert property (@(posedge pclk) disable iff (!presetn)
    acc && key_ff == fpe_pkg::FPE_KEY_HALF && !(wr_acc && paddr == `FPE_OFS_KEY)
    |=> key_ff == fpe_pkg::FPE_KEY_NONE)
    else $error("unlock not cancelled by other access");
endmodule // fpe_ctrl
`default_nettype wire

// ### fpe_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module fpe_flash_model (
  // Clock.
  input wire logic pclk,
  // Read port.
  input wire logic flash_rd_en,
  input wire logic [21:0] flash_rd_addr,
  output logic [7:0] flash_rd_data,
  // Erase and program strobes.
  input wire logic flash_erase_strobe,
  input wire logic [11:0] flash_erase_block,
  input wire logic flash_wr_strobe,
  input wire logic [21:0] flash_wr_addr,
  input wire logic [7:0] flash_wr_data
);
  logic [7:0] mem [int];
  int n_erase = 0;
  int n_wr = 0;
  logic [11:0] last_blk = 12'h000;
  logic [7:0] idle_q = 8'h00;
  // Unwritten cells read a pattern tied to the address.
  // The byte stands only while the enable is high; otherwise the data toggles,
  // so a sample taken in the wrong cycle shows up.
  always @(posedge pclk) idle_q <= ~idle_q;
  always @(flash_rd_en or flash_rd_addr or idle_q) begin
    if (flash_rd_en)
      flash_rd_data = mem.exists(int'(flash_rd_addr)) ? mem[int'(flash_rd_addr)] :
                      flash_rd_addr[7:0] ^ 8'h3c;
    else
      flash_rd_data = idle_q;
  end
  always @(posedge pclk) begin
    if (flash_erase_strobe) begin
      n_erase++;
      last_blk = flash_erase_block;
      for (int i = 0; i < 1024; i++)
        mem[int'({flash_erase_block, 10'h000}) + i] = 8'hff;
    end
    if (flash_wr_strobe) begin
      n_wr++;
      mem[int'(flash_wr_addr)] = flash_wr_data;
    end
  end
endmodule // fpe_flash_model
`default_nettype wire

// ### self_program_flash_erase_write_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpe_map.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module self_program_flash_erase_write_test;
  localparam int LWC = 100;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic write_abort = 1'b0;
  logic pready, pslverr, cpu_stall, rd_en, er_stb, wr_stb, serr;
  logic [31:0] prdata, rd;
  logic [21:0] rd_addr, wr_addr, p, eff;
  logic [7:0] rd_data, wr_data;
  logic [11:0] er_blk;
  int err_total = 0;
  int n_compared = 0;
  int stall_cnt = 0;
  int modes [5] = '{1, 1, 0, 2, 3};
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) if (cpu_stall === 1'b1) stall_cnt++;
  fpe_ctrl #(.LONG_WRITE_CYCLES(LWC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .write_abort(write_abort), .flash_rd_en(rd_en),
    .flash_rd_addr(rd_addr), .flash_rd_data(rd_data), .flash_erase_strobe(er_stb),
    .flash_erase_block(er_blk), .flash_wr_strobe(wr_stb), .flash_wr_addr(wr_addr),
    .flash_wr_data(wr_data), .cpu_stall(cpu_stall));
  fpe_flash_model mdl (.pclk(pclk), .flash_rd_en(rd_en), .flash_rd_addr(rd_addr),
    .flash_rd_data(rd_data), .flash_erase_strobe(er_stb), .flash_erase_block(er_blk),
    .flash_wr_strobe(wr_stb), .flash_wr_addr(wr_addr), .flash_wr_data(wr_data));
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      err_total++;
      close_out();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic key();
    apb(1'b1, `FPE_OFS_KEY, {24'h0, `FPE_KEY_FIRST});
    apb(1'b1, `FPE_OFS_KEY, {24'h0, `FPE_KEY_SECOND});
  endtask
  // Waits out a long write; a hang past the bound ends the run.
  task automatic wait_idle();
    int n;
    n = 0;
    while (cpu_stall !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      err_total++;
      close_out();
    end
    @(posedge pclk);
  endtask
  task automatic check_row(input int base);
    for (int i = 0; i < 64; i++)
      `CHK(mdl.mem[base + i], 8'(i * 7 + 5))
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `FPE_OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(serr, 1'b1)
    apb(1'b1, `FPE_OFS_CTRL, 32'h96);
    key();
    apb(1'b1, `FPE_OFS_CTRL, 32'h92);
    key();
    apb(1'b1, `FPE_OFS_CTRL, 32'hd6);
    apb(1'b1, `FPE_OFS_KEY, {24'h0, `FPE_KEY_FIRST});
    apb(1'b0, `FPE_OFS_STAT, 32'h0);
    apb(1'b1, `FPE_OFS_KEY, {24'h0, `FPE_KEY_SECOND});
    apb(1'b1, `FPE_OFS_CTRL, 32'h96);
    `CHK(mdl.n_erase, 0)
    `CHK(stall_cnt, 0)
    apb(1'b0, `FPE_OFS_CTRL, 32'h0);
    `CHK(rd[1], 1'b0)
    p = 22'h000100;
    apb(1'b1, `FPE_OFS_PTR, {10'h0, p});
    foreach (modes[k]) begin
      apb(1'b1, `FPE_OFS_TOP, modes[k]);
      eff = (modes[k] == 3) ? p + 22'h1 : p;
      apb(1'b0, `FPE_OFS_LATCH, 32'h0);
      `CHK(rd[7:0], eff[7:0] ^ 8'h3c)
      p = (modes[k] == 1) ? p + 22'h1 : (modes[k] == 2) ? p - 22'h1 : eff;
      apb(1'b0, `FPE_OFS_PTR, 32'h0);
      `CHK(rd[21:0], p)
    end
    apb(1'b1, `FPE_OFS_PTR, 32'h000153ff);
    stall_cnt = 0;
    key();
    apb(1'b1, `FPE_OFS_CTRL, 32'h96);
    wait_idle();
    `CHK(stall_cnt, LWC)
    `CHK(mdl.n_erase, 1)
    `CHK(mdl.last_blk, 12'h054)
    `CHK(mdl.mem[32'h15000], 8'hff)
    `CHK(mdl.mem.exists(32'h15400) != 0, 1'b0)
    apb(1'b0, `FPE_OFS_CTRL, 32'h0);
    `CHK(rd[1], 1'b0)
    // Pointer starts one below the row, loaded with pre-increment.
    apb(1'b1, `FPE_OFS_PTR, 32'h0001503f);
    for (int i = 0; i < 64; i++) begin
      apb(1'b1, `FPE_OFS_LATCH, {24'h0, 8'(i * 7 + 5)});
      apb(1'b1, `FPE_OFS_TOP, 32'h7);
    end
    `CHK(mdl.n_wr, 0)
    stall_cnt = 0;
    key();
    apb(1'b1, `FPE_OFS_CTRL, 32'h86);
    wait_idle();
    `CHK(mdl.n_wr, 64)
    `CHK(mdl.n_erase, 1)
    `CHK(stall_cnt, LWC)
    check_row(32'h15040);
    apb(1'b1, `FPE_OFS_PTR, 32'h00015080);
    key();
    apb(1'b1, `FPE_OFS_CTRL, 32'h86);
    wait_idle();
    check_row(32'h15080);
    stall_cnt = 0;
    key();
    apb(1'b1, `FPE_OFS_CTRL, 32'h96);
    repeat (10) @(posedge pclk);
    write_abort <= 1'b1;
    wait_idle();
    write_abort <= 1'b0;
    `CHK(stall_cnt < LWC, 1'b1)
    apb(1'b0, `FPE_OFS_CTRL, 32'h0);
    `CHK(rd[3], 1'b1)
    close_out();
  end
endmodule // self_program_flash_erase_write_test
`default_nettype wire
